// [src/cwr_context.sv]
/*
  Working-register file with two alternate banked sets, stack pointer,
  program counter register and context status.
  Assumes the execution unit and interrupt logic share i_clock.
*/
`timescale 1ns/1ps
module cwr_context (
  // Clock, reset and enable.
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  // Working-register access from the execution unit.
  input wire logic i_wr,
  input wire logic [cwr_pkg::CWR_ADDR_W-1:0] i_waddr,
  input wire logic [cwr_pkg::CWR_DATA_W-1:0] i_wdata,
  input wire logic [cwr_pkg::CWR_ADDR_W-1:0] i_raddr_a,
  input wire logic [cwr_pkg::CWR_ADDR_W-1:0] i_raddr_b,
  output logic [cwr_pkg::CWR_DATA_W-1:0] o_rdata_a,
  output logic [cwr_pkg::CWR_DATA_W-1:0] o_rdata_b,
  // Stack pointer push and pop.
  input wire logic i_sp_push,
  input wire logic i_sp_pop,
  output logic [cwr_pkg::CWR_DATA_W-1:0] o_stack_pointer,
  // Program counter.
  input wire logic i_pc_load,
  input wire logic [cwr_pkg::CWR_PC_W-1:0] i_pc_value,
  output logic [cwr_pkg::CWR_PC_W-1:0] o_pc,
  // Interrupt entry and return.
  input wire logic i_irq_enter,
  input wire logic [cwr_pkg::CWR_SET_W-1:0] i_irq_level,
  input wire logic i_irq_return,
  input wire logic [cwr_pkg::CWR_SET_W-1:0] i_return_set,
  // Context swap instruction.
  input wire logic i_ctx_swap,
  input wire logic [cwr_pkg::CWR_SET_W-1:0] i_swap_set,
  // Software register port.
  input wire logic [cwr_pkg::CWR_ADDR_W-1:0] i_sw_addr,
  input wire logic [cwr_pkg::CWR_DATA_W-1:0] i_sw_wdata,
  input wire logic i_sw_write,
  input wire logic i_sw_read,
  output logic [cwr_pkg::CWR_DATA_W-1:0] o_sw_rdata,
  // Active set for the execution unit.
  output logic [cwr_pkg::CWR_SET_W-1:0] o_current_set_id
);
  import cwr_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [CWR_DATA_W-1:0] prim_reg [CWR_BANKED];
  logic [CWR_DATA_W-1:0] stack_pointer_register_reg;
  logic [CWR_PC_W-1:0] pc_reg;
  logic [CWR_DATA_W-1:0] alternate_set_config_word_reg;
  logic [CWR_SET_W-1:0] current_set_id_reg;
  logic [CWR_SET_W-1:0] current_set_id_next;
  logic [CWR_SET_W-1:0] manual_set_id_reg;
  logic [CWR_DATA_W-1:0] sw_rdata_reg;
  logic [CWR_DATA_W-1:0] alt1_a;
  logic [CWR_DATA_W-1:0] alt1_b;
  logic [CWR_DATA_W-1:0] alt2_a;
  logic [CWR_DATA_W-1:0] alt2_b;
  logic [CWR_SET_W-1:0] alt1_level;
  logic [CWR_SET_W-1:0] alt2_level;
  logic wr_sp;

  // A level outside 1..6 never binds a set.
  function automatic logic level_ok(input logic [CWR_SET_W-1:0] lvl);
    return (lvl >= CWR_LEVEL_MIN) && (lvl <= CWR_LEVEL_MAX);
  endfunction

  // Only the primary and two alternate sets exist; other ids are ignored.
  function automatic logic set_ok(input logic [CWR_SET_W-1:0] s);
    return (s == CWR_SET_PRIMARY) || (s == CWR_SET_ALT1) || (s == CWR_SET_ALT2);
  endfunction

  // Pick a word from the active set, with the shared stack pointer on top.
  function automatic logic [CWR_DATA_W-1:0] pick(
    input logic [CWR_ADDR_W-1:0] a,
    input logic [CWR_SET_W-1:0] s,
    input logic [CWR_DATA_W-1:0] p,
    input logic [CWR_DATA_W-1:0] x1,
    input logic [CWR_DATA_W-1:0] x2,
    input logic [CWR_DATA_W-1:0] sp
  );
    if (a == CWR_SP_INDEX) begin
      return sp;
    end else if (s == CWR_SET_ALT1) begin
      return x1;
    end else if (s == CWR_SET_ALT2) begin
      return x2;
    end
    return p;
  endfunction

  assign alt1_level = alternate_set_config_word_reg[CWR_ALT1_LSB +: CWR_SET_W];
  assign alt2_level = alternate_set_config_word_reg[CWR_ALT2_LSB +: CWR_SET_W];
  assign wr_sp = i_wr && (i_waddr == CWR_SP_INDEX);

  // ************************************************************
  // Banked storage
  // ************************************************************

  // Primary copy of registers 0 to 14.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < CWR_BANKED; i++) begin
        prim_reg[i] <= CWR_ZERO;
      end
    end else if (i_ce && i_wr && !wr_sp && current_set_id_reg == CWR_SET_PRIMARY) begin
      prim_reg[i_waddr] <= i_wdata;
    end
  end

  // Alternate sets only see writes while they are the active set.
  cwr_bank u_alt1 (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_wr(i_wr && current_set_id_reg == CWR_SET_ALT1),
    .i_waddr(i_waddr),
    .i_wdata(i_wdata),
    .i_raddr_a(i_raddr_a),
    .i_raddr_b(i_raddr_b),
    .o_rdata_a(alt1_a),
    .o_rdata_b(alt1_b)
  );

  cwr_bank u_alt2 (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_wr(i_wr && current_set_id_reg == CWR_SET_ALT2),
    .i_waddr(i_waddr),
    .i_wdata(i_wdata),
    .i_raddr_a(i_raddr_a),
    .i_raddr_b(i_raddr_b),
    .o_rdata_a(alt2_a),
    .o_rdata_b(alt2_b)
  );

  // Operand reads are combinational so an operand is ready in its own cycle.
  assign o_rdata_a = pick(i_raddr_a, current_set_id_reg, prim_reg[i_raddr_a], alt1_a, alt2_a,
                          stack_pointer_register_reg);
  assign o_rdata_b = pick(i_raddr_b, current_set_id_reg, prim_reg[i_raddr_b], alt1_b, alt2_b,
                          stack_pointer_register_reg);

  // ************************************************************
  // Stack pointer and program counter
  // ************************************************************

  // Shared across sets; a direct write beats a push or pop in the same cycle.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stack_pointer_register_reg <= CWR_ZERO;
    end else if (i_ce) begin
      if (wr_sp) begin
        stack_pointer_register_reg <= i_wdata;
      end else if (i_sp_push && !i_sp_pop) begin
        stack_pointer_register_reg <= stack_pointer_register_reg + CWR_SP_STEP;
      end else if (i_sp_pop && !i_sp_push) begin
        stack_pointer_register_reg <= stack_pointer_register_reg - CWR_SP_STEP;
      end
    end
  end

  // Program counter holds a word address into program memory.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pc_reg <= CWR_PC_RESET;
    end else if (i_ce && i_pc_load) begin
      pc_reg <= i_pc_value;
    end
  end

  assign o_stack_pointer = stack_pointer_register_reg;
  assign o_pc = pc_reg;

  // ************************************************************
  // Set selection
  // ************************************************************

  // Swap wins over interrupt entry; return restores the set the core saved.
  always_comb begin
    current_set_id_next = current_set_id_reg;
    if (i_ctx_swap && set_ok(i_swap_set)) begin
      current_set_id_next = i_swap_set;
    end else if (i_irq_enter) begin
      if (level_ok(alt1_level) && i_irq_level == alt1_level) begin
        current_set_id_next = CWR_SET_ALT1;
      end else if (level_ok(alt2_level) && i_irq_level == alt2_level) begin
        current_set_id_next = CWR_SET_ALT2;
      end else begin
        current_set_id_next = CWR_SET_PRIMARY;
      end
    end else if (i_irq_return && set_ok(i_return_set)) begin
      current_set_id_next = i_return_set;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      current_set_id_reg <= CWR_SET_PRIMARY;
    end else if (i_ce) begin
      current_set_id_reg <= current_set_id_next;
    end
  end

  // Records only explicit swaps, not interrupt-driven changes.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      manual_set_id_reg <= CWR_SET_PRIMARY;
    end else if (i_ce && i_ctx_swap && set_ok(i_swap_set)) begin
      manual_set_id_reg <= i_swap_set;
    end
  end

  assign o_current_set_id = current_set_id_reg;

  // ************************************************************
  // Software register port
  // ************************************************************

  // Only the two level fields are writable; other bits stay zero.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      alternate_set_config_word_reg <= CWR_ALT_CFG_RESET;
    end else if (i_ce && i_sw_write && i_sw_addr == CWR_OFF_ALT_CFG) begin
      alternate_set_config_word_reg <= CWR_ZERO;
      alternate_set_config_word_reg[CWR_ALT1_LSB +: CWR_SET_W] <= i_sw_wdata[CWR_ALT1_LSB +: CWR_SET_W];
      alternate_set_config_word_reg[CWR_ALT2_LSB +: CWR_SET_W] <= i_sw_wdata[CWR_ALT2_LSB +: CWR_SET_W];
    end
  end

  // Read data appears the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sw_rdata_reg <= CWR_ZERO;
    end else if (i_ce) begin
      sw_rdata_reg <= CWR_ZERO;
      if (i_sw_read) begin
        if (i_sw_addr == CWR_OFF_ALT_CFG) begin
          sw_rdata_reg <= alternate_set_config_word_reg;
        end else if (i_sw_addr == CWR_OFF_STATUS) begin
          sw_rdata_reg[CWR_CUR_LSB +: CWR_SET_W] <= current_set_id_reg;
          sw_rdata_reg[CWR_MAN_LSB +: CWR_SET_W] <= manual_set_id_reg;
        end
      end
    end
  end

  assign o_sw_rdata = sw_rdata_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  AST_SWAP_SELECTS: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_ctx_swap && set_ok(i_swap_set) |=> current_set_id_reg == $past(i_swap_set))
    else $error("swap did not select named set");
  AST_MANUAL_TRACKS: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_ctx_swap && set_ok(i_swap_set) |=> manual_set_id_reg == current_set_id_reg)
    else $error("manual id differs from swapped set");
  AST_IRQ_BINDS: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_irq_enter && !i_ctx_swap && level_ok(alt1_level) && i_irq_level == alt1_level
    |=> current_set_id_reg == CWR_SET_ALT1)
    else $error("bound set not activated on entry");
  AST_SP_SHARED: assert property (@(posedge i_clock) disable iff (i_rst)
    o_rdata_a == stack_pointer_register_reg || i_raddr_a != CWR_SP_INDEX)
    else $error("stack pointer read mismatch");
  AST_SP_PUSH: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_sp_push && !i_sp_pop && !wr_sp |=> stack_pointer_register_reg == $past(stack_pointer_register_reg) + CWR_SP_STEP)
    else $error("push did not advance stack pointer");
  AST_WRITE_READBACK: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_wr && i_raddr_a == i_waddr ##1 current_set_id_reg == $past(current_set_id_reg)
    |-> o_rdata_a == $past(i_wdata) || i_raddr_a != $past(i_raddr_a))
    else $error("written word not read back");
  AST_PERSIST: assert property (@(posedge i_clock) disable iff (i_rst)
    current_set_id_reg != CWR_SET_ALT1 |=> u_alt1.mem_reg[0] == $past(u_alt1.mem_reg[0]))
    else $error("inactive set changed");
  AST_PC_LOAD: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_pc_load |=> o_pc == $past(i_pc_value))
    else $error("pc not loaded");
  AST_STATUS_READ: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_sw_read && i_sw_addr == CWR_OFF_STATUS
    |=> o_sw_rdata[CWR_CUR_LSB +: CWR_SET_W] == $past(current_set_id_reg))
    else $error("status read wrong");
  AST_RESET_PRIMARY: assert property (@(posedge i_clock)
    $fell(i_rst) |-> current_set_id_reg == CWR_SET_PRIMARY && manual_set_id_reg == CWR_SET_PRIMARY)
    else $error("reset did not select primary");

  COV_SWAP: cover property (@(posedge i_clock) disable iff (i_rst) i_ce && i_ctx_swap);
  COV_IRQ_ALT: cover property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_irq_enter ##1 current_set_id_reg != CWR_SET_PRIMARY);
  COV_RETURN: cover property (@(posedge i_clock) disable iff (i_rst) i_ce && i_irq_return);
endmodule

// [include/cwr_pkg.sv]
/*
  Constants and types for the working-register context block.
  Assumes a single core clock and a plain register port from the core.
*/
package cwr_pkg;

  // ************************************************************
  // Widths and counts
  // ************************************************************
  localparam int CWR_DATA_W = 16;
  localparam int CWR_NUM_REGS = 16;
  localparam int CWR_ADDR_W = 4;
  localparam int CWR_SET_W = 3;
  localparam int CWR_PC_W = 23;
  localparam int CWR_NUM_ALT = 2;
  localparam int CWR_BANKED = 15;

  // ************************************************************
  // Register indices and set identifiers
  // ************************************************************
  localparam logic [CWR_ADDR_W-1:0] CWR_SP_INDEX = 4'hF;
  localparam logic [CWR_SET_W-1:0] CWR_SET_PRIMARY = 3'h0;
  localparam logic [CWR_SET_W-1:0] CWR_SET_ALT1 = 3'h1;
  localparam logic [CWR_SET_W-1:0] CWR_SET_ALT2 = 3'h2;
  localparam logic [CWR_SET_W-1:0] CWR_LEVEL_MIN = 3'h1;
  localparam logic [CWR_SET_W-1:0] CWR_LEVEL_MAX = 3'h6;

  // ************************************************************
  // Software-visible register offsets and fields
  // ************************************************************
  localparam logic [CWR_ADDR_W-1:0] CWR_OFF_ALT_CFG = 4'h0;
  localparam logic [CWR_ADDR_W-1:0] CWR_OFF_STATUS = 4'h2;
  localparam int CWR_ALT1_LSB = 0;
  localparam int CWR_ALT2_LSB = 4;
  localparam int CWR_CUR_LSB = 0;
  localparam int CWR_MAN_LSB = 8;
  localparam logic [CWR_DATA_W-1:0] CWR_ALT_CFG_RESET = 16'h0000;
  localparam logic [CWR_DATA_W-1:0] CWR_ZERO = 16'h0000;
  localparam logic [CWR_DATA_W-1:0] CWR_SP_STEP = 16'h0002;
  localparam logic [CWR_PC_W-1:0] CWR_PC_RESET = 23'h000000;

endpackage

// [src/cwr_bank.sv]
/*
  One banked copy of registers 0 to 14.
  Assumes the parent enables writes only for the set it owns.
*/
`timescale 1ns/1ps
module cwr_bank (
  // Clock, reset and enable.
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  // Write port.
  input wire logic i_wr,
  input wire logic [cwr_pkg::CWR_ADDR_W-1:0] i_waddr,
  input wire logic [cwr_pkg::CWR_DATA_W-1:0] i_wdata,
  // Read ports.
  input wire logic [cwr_pkg::CWR_ADDR_W-1:0] i_raddr_a,
  input wire logic [cwr_pkg::CWR_ADDR_W-1:0] i_raddr_b,
  output logic [cwr_pkg::CWR_DATA_W-1:0] o_rdata_a,
  output logic [cwr_pkg::CWR_DATA_W-1:0] o_rdata_b
);
  import cwr_pkg::*;

  logic [CWR_DATA_W-1:0] mem_reg [CWR_BANKED];

  // Contents persist while the bank is inactive, so handlers find old values.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < CWR_BANKED; i++) begin
        mem_reg[i] <= CWR_ZERO;
      end
    end else if (i_ce && i_wr && i_waddr != CWR_SP_INDEX) begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  // Index 15 never lives here; the parent substitutes the stack pointer.
  assign o_rdata_a = (i_raddr_a == CWR_SP_INDEX) ? CWR_ZERO : mem_reg[i_raddr_a];
  assign o_rdata_b = (i_raddr_b == CWR_SP_INDEX) ? CWR_ZERO : mem_reg[i_raddr_b];
endmodule

// [verif/cwr_core_model.sv]
/*
  Model of the interrupt logic around the register context.
  Assumes the bench asks for interrupt entry and return with one-cycle pulses.
*/
`timescale 1ns/1ps
module cwr_core_model (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst,
  // Requests from the bench, and the active set from the context block.
  input wire logic i_req_enter,
  input wire logic [cwr_pkg::CWR_SET_W-1:0] i_req_level,
  input wire logic i_req_return,
  input wire logic [cwr_pkg::CWR_SET_W-1:0] i_cur_set,
  // Interrupt side of the context block.
  output logic o_irq_enter,
  output logic [cwr_pkg::CWR_SET_W-1:0] o_irq_level,
  output logic o_irq_return,
  output logic [cwr_pkg::CWR_SET_W-1:0] o_return_set
);
  import cwr_pkg::*;
  // ************************************************************
  // Entry and return sequencing
  // ************************************************************
  logic [CWR_SET_W-1:0] saved_reg;
  // The set in use at entry is kept so that the return restores it.
  // Idle qualifier lines flip every cycle so a stale value is never trusted.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_irq_enter <= 1'b0;
      o_irq_return <= 1'b0;
      o_irq_level <= 3'h0;
      o_return_set <= 3'h0;
      saved_reg <= 3'h0;
    end else begin
      o_irq_enter <= i_req_enter;
      o_irq_return <= i_req_return;
      o_irq_level <= i_req_enter ? i_req_level : ~o_irq_level;
      o_return_set <= i_req_return ? saved_reg : ~o_return_set;
      if (i_req_enter) begin
        saved_reg <= i_cur_set;
      end
    end
  end
endmodule

// [verif/tb.sv]
/*
  Self-checking bench for the working-register context block.
  Assumes the core model drives interrupt entry and return.
*/
`timescale 1ns/1ps
module tb;
  import cwr_pkg::*;
  // ************************************************************
  // Signals, clock, instances
  // ************************************************************
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, push = 1'b0, pop = 1'b0;
  logic pc_load = 1'b0, swap = 1'b0, sw_write = 1'b0, sw_read = 1'b0;
  logic req_enter = 1'b0, req_return = 1'b0, irq_enter, irq_return;
  logic [3:0] waddr = 4'h0, raddr_a = 4'h0, raddr_b = 4'h0, sw_addr = 4'h0;
  logic [15:0] wdata = 16'h0000, sw_wdata = 16'h0000, rdata_a, rdata_b, sp, sw_rdata, d;
  logic [22:0] pc_value = 23'h000000, pc;
  logic [2:0] swap_set = 3'h0, req_level = 3'h0, irq_level, return_set, cur;
  int fail_count = 0, n_checks = 0;
  // The clock inverts each half period of 12.5 ns.
  initial begin
    forever #12.5 clk = ~clk;
  end
  cwr_context i_dut (.i_clock(clk), .i_rst(rst), .i_ce(ce), .i_wr(wr), .i_waddr(waddr), .i_wdata(wdata),
    .i_raddr_a(raddr_a), .i_raddr_b(raddr_b), .o_rdata_a(rdata_a), .o_rdata_b(rdata_b), .i_sp_push(push),
    .i_sp_pop(pop), .o_stack_pointer(sp), .i_pc_load(pc_load), .i_pc_value(pc_value), .o_pc(pc),
    .i_irq_enter(irq_enter), .i_irq_level(irq_level), .i_irq_return(irq_return), .i_return_set(return_set),
    .i_ctx_swap(swap), .i_swap_set(swap_set), .i_sw_addr(sw_addr), .i_sw_wdata(sw_wdata),
    .i_sw_write(sw_write), .i_sw_read(sw_read), .o_sw_rdata(sw_rdata), .o_current_set_id(cur));
  cwr_core_model i_core (.i_clock(clk), .i_rst(rst), .i_req_enter(req_enter), .i_req_level(req_level),
    .i_req_return(req_return), .i_cur_set(cur), .o_irq_enter(irq_enter), .o_irq_level(irq_level),
    .o_irq_return(irq_return), .o_return_set(return_set));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // The reg_wr, sw_wr and sw_rd tasks return on the edge that drops their strobe, so the next call starts one edge later.
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1; waddr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    raddr_a <= a; raddr_b <= a;
    #1;
    chk(rdata_a, exp);
    chk(rdata_b, exp);
  endtask
  task automatic sw_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    sw_write <= 1'b1; sw_addr <= a; sw_wdata <= v;
    @(posedge clk);
    sw_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken right there.
  task automatic sw_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    sw_read <= 1'b1; sw_addr <= a;
    @(posedge clk);
    sw_read <= 1'b0;
    #1;
    v = sw_rdata;
  endtask
  task automatic irq(input logic enter, input logic [2:0] lvl, input logic [2:0] exp);
    @(posedge clk);
    if (enter) begin
      req_enter <= 1'b1; req_level <= lvl;
    end else begin
      req_return <= 1'b1;
    end
    @(posedge clk);
    req_enter <= 1'b0; req_return <= 1'b0;
    @(posedge clk);
    #1;
    chk(cur, exp);
  endtask
  task automatic do_swap(input logic [2:0] s, input logic [2:0] exp);
    @(posedge clk);
    swap <= 1'b1; swap_set <= s;
    @(posedge clk);
    swap <= 1'b0;
    #1;
    chk(cur, exp);
    sw_rd(CWR_OFF_STATUS, d);
    chk(d, (16'(exp) << CWR_MAN_LSB) | 16'(exp));
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    chk(cur, CWR_SET_PRIMARY);
    chk(sp, 16'h0000);
    chk(pc, CWR_PC_RESET);
    sw_rd(CWR_OFF_STATUS, d);
    chk(d, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 16; i++) reg_wr(4'(i), 16'hA500 | 16'(i));
    for (int i = 0; i < 16; i++) reg_chk(4'(i), 16'hA500 | 16'(i));
    chk(sp, 16'hA50F);
    @(posedge clk); push <= 1'b1;
    @(posedge clk); push <= 1'b0;
    #1 chk(sp, 16'hA511);
    @(posedge clk); pop <= 1'b1;
    @(posedge clk); pop <= 1'b0;
    #1 chk(sp, 16'hA50F);
    $display("test regs done");
  endtask
  task automatic t_irq();
    sw_wr(CWR_OFF_ALT_CFG, 16'hFFD3);
    sw_rd(CWR_OFF_ALT_CFG, d);
    chk(d, 16'h0053);
    irq(1'b1, 3'h3, CWR_SET_ALT1);
    for (int i = 0; i < 15; i++) reg_wr(4'(i), 16'h5A00 | 16'(i));
    reg_chk(CWR_SP_INDEX, 16'hA50F);
    irq(1'b0, 3'h0, CWR_SET_PRIMARY);
    for (int i = 0; i < 15; i++) reg_chk(4'(i), 16'hA500 | 16'(i));
    irq(1'b1, 3'h5, CWR_SET_ALT2);
    reg_chk(4'h0, 16'h0000);
    irq(1'b0, 3'h0, CWR_SET_PRIMARY);
    irq(1'b1, 3'h3, CWR_SET_ALT1);
    for (int i = 0; i < 15; i++) reg_chk(4'(i), 16'h5A00 | 16'(i));
    irq(1'b0, 3'h0, CWR_SET_PRIMARY);
    irq(1'b1, 3'h7, CWR_SET_PRIMARY);
    irq(1'b0, 3'h0, CWR_SET_PRIMARY);
    $display("test irq done");
  endtask
  task automatic t_swap();
    do_swap(3'h2, CWR_SET_ALT2);
    do_swap(3'h5, CWR_SET_ALT2);
    do_swap(3'h1, CWR_SET_ALT1);
    reg_chk(4'h1, 16'h5A01);
    do_swap(3'h0, CWR_SET_PRIMARY);
    sw_wr(4'h6, 16'hFFFF);
    sw_rd(4'h6, d);
    chk(d, 16'h0000);
    sw_rd(CWR_OFF_ALT_CFG, d);
    chk(d, 16'h0053);
    $display("test swap done");
  endtask
  task automatic t_pc();
    @(posedge clk); pc_load <= 1'b1; pc_value <= 23'h7FFFFF;
    @(posedge clk); pc_load <= 1'b0;
    #1 chk(pc, 23'h7FFFFF);
    $display("test pc done");
  endtask
  // Enable low freezes every register, so strobes in that window must be lost.
  task automatic t_ce();
    @(posedge clk);
    ce <= 1'b0;
    push <= 1'b1;
    swap <= 1'b1;
    swap_set <= CWR_SET_ALT2;
    pc_load <= 1'b1;
    pc_value <= 23'h000123;
    sw_write <= 1'b1;
    sw_addr <= CWR_OFF_ALT_CFG;
    sw_wdata <= 16'h0011;
    @(posedge clk);
    push <= 1'b0;
    swap <= 1'b0;
    pc_load <= 1'b0;
    sw_write <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    #1;
    chk(sp, 16'hA50F);
    chk(cur, CWR_SET_PRIMARY);
    chk(pc, 23'h7FFFFF);
    sw_rd(CWR_OFF_ALT_CFG, d);
    chk(d, 16'h0053);
    $display("test ce done");
  endtask
  // Swap and interrupt entry meet in one cycle: the swap names the set.
  task automatic t_prio();
    @(posedge clk);
    req_enter <= 1'b1;
    req_level <= 3'h3;
    @(posedge clk);
    req_enter <= 1'b0;
    swap <= 1'b1;
    swap_set <= CWR_SET_ALT2;
    @(posedge clk);
    swap <= 1'b0;
    #1;
    chk(cur, CWR_SET_ALT2);
    do_swap(3'h0, CWR_SET_PRIMARY);
    $display("test priority done");
  endtask
  // A second reset in mid-run must clear a non-primary manual id, the primary set and the first alternate set.
  task automatic t_rst2();
    do_swap(3'h2, CWR_SET_ALT2);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(cur, CWR_SET_PRIMARY);
    chk(sp, 16'h0000);
    chk(pc, CWR_PC_RESET);
    reg_chk(4'h0, 16'h0000);
    sw_rd(CWR_OFF_STATUS, d);
    chk(d, 16'h0000);
    do_swap(3'h1, CWR_SET_ALT1);
    reg_chk(4'h1, 16'h0000);
    $display("test reset again done");
  endtask
  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_irq();
    t_swap();
    t_pc();
    t_ce();
    t_prio();
    t_rst2();
    end_sim();
  end
  // About 200 cycles are expected; the limit leaves wide margin.
  initial begin
    #(25 * 5000);
    fail_count++;
    end_sim();
  end
endmodule
